// *** verilog/mcir_top.sv ***
// Purpose: Indirect read path for the switch statistics counters over the serial port
//   Three blocks of per-port counters and six dropped-packet counters sit behind it
// Assumes: Counter events are one-cycle pulses on the core clock; one count each
//   They come from port logic on this same clock, so they pass no synchroniser
// Notes: Per-port counters clear when fetched, dropped-packet counters are never cleared by a fetch
//   The whole word is latched on the offset write, so slow byte reads never tear
//   Unknown tables and offsets outside both areas fetch a zero word with valid low
`timescale 1ns/1ns
module mcir_top
  import mcir_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  input wire logic i_spi_sclk,
  input wire logic i_spi_cs_n,
  input wire logic i_spi_mosi,
  output logic o_spi_miso,
  output logic o_spi_miso_oe,
  input wire logic [NUM_PORT_CNT-1:0] i_port_stat_inc,
  input wire logic [NUM_DROP-1:0] i_drop_inc,
  output logic o_fetch_busy
);

  // Decoded indirect target
  // At most one of the two hits is set, and an index means nothing without its hit
  typedef struct packed {
    logic port_hit;
    logic drop_hit;
    logic [6:0] port_idx;
    logic [2:0] drop_idx;
  } mcir_target_t;

  mcir_reg_wr_t wr; // Write from the serial port
  logic [ADDR_W-1:0] rd_addr; // Read address from the serial port
  logic [DATA_W-1:0] rd_data; // Read data to the serial port
  logic [7:0] table_sel_ff; // Indirect table select
  logic [7:0] offset_ff; // Last written indirect offset
  mcir_snap_t snap_ff; // Latched counter snapshot
  mcir_snap_t nxt_snap; // Snapshot to latch on a trigger
  mcir_snap_t port_word; // Per-port word for the decoded target
  mcir_snap_t drop_word; // Dropped-counter word for the decoded target
  logic trigger; // Offset write that starts a fetch
  mcir_target_t tgt; // Target decoded from the trigger write
  logic [NUM_PORT_CNT-1:0] port_clr; // One-hot clear to the fetched cell
  logic [PORT_CNT_W-1:0] port_count [NUM_PORT_CNT]; // Per-port counts
  logic [NUM_PORT_CNT-1:0] port_ovf; // Per-port overflow flags
  logic [DROP_CNT_W-1:0] drop_cnt_ff [NUM_DROP]; // Dropped-packet counters
  logic fetch_ff; // Fetch strobe seen by the status output

  // Decode a table select and offset into a counter target
  // Only the select that stands before the offset write counts, so the order of writes matters
  function automatic mcir_target_t decode_target(input logic [7:0] table_sel, input logic [7:0] offset);
    mcir_target_t t;
    t = '0;
    // Per-port table: blocks of 32 at 0x00, 0x20, 0x40 give a flat index
    if (table_sel == TABLE_PER_PORT)
    begin
      // Offsets 0x60 and above fall outside all three blocks and miss
      t.port_hit = (offset < PORT_AREA_END);
      t.port_idx = offset[6:0];
    end
    // Dropped table: low offset byte plus the 0x100 area base
    else if (table_sel == TABLE_DROP)
    begin
      // Only 0x00 to 0x05 land on a counter; higher offsets miss
      t.drop_hit = ({1'b0, offset} | DROP_AREA_BASE) <= PORT_THREE_RX_DISCARD_COUNT;
      t.drop_idx = offset[2:0];
    end
    return t;
  endfunction

  // True when the port writes the given register in this cycle
  function automatic logic reg_write_hit(input mcir_reg_wr_t w, input logic [ADDR_W-1:0] a);
    return w.valid && (w.addr == a);
  endfunction

  // Serial register port
  // Every register access, read or write, goes through this one port
  // It gives one write strobe per data byte of a write command and holds the read address for the whole byte
  // Read data below is combinational and is registered in the port's shift register
  mcir_spi_slave u_spi
  (
    .i_ref_clk(i_ref_clk),
    .i_nrst(i_nrst),
    .i_spi_sclk(i_spi_sclk),
    .i_spi_cs_n(i_spi_cs_n),
    .i_spi_mosi(i_spi_mosi),
    .o_spi_miso(o_spi_miso),
    .o_spi_miso_oe(o_spi_miso_oe),
    .o_rd_addr(rd_addr),
    .i_rd_data(rd_data),
    .o_wr(wr)
  );

  // A write to the offset register is the fetch trigger
  // The strobe lasts one cycle, so one access can never fetch twice
  assign trigger = reg_write_hit(wr, REG_OFFSET_TRIG);

  // Decode against the table select that stands when the offset is written
  // A burst writing the select then the offset works: the select lands eight bits earlier
  assign tgt = decode_target(table_sel_ff, wr.data);

  // Table select register
  // Any value is stored; only the two table codes decode to counters
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_nrst)
    begin
      // Reset selects no table, so a fetch before setup reads a zero word
      table_sel_ff <= TABLE_SEL_RST;
    end
    else if (reg_write_hit(wr, REG_TABLE_SEL))
    begin
      // Stored whole, even an unknown table code
      table_sel_ff <= wr.data;
    end
  end

  // Offset register, read back as written
  // Kept only for read-back; the fetch uses the write data directly
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_nrst)
    begin
      // Reads back as zero until the first offset write
      offset_ff <= OFFSET_TRIG_RST;
    end
    else if (trigger)
    begin
      // Every trigger write updates the read-back copy
      offset_ff <= wr.data;
    end
  end

  // Per-port counter cells, with the clear pulse going only to the fetched one
  // Ninety-six cells in three blocks of thirty-two, flat-indexed by the offset byte
  genvar gi;
  generate
    for (gi = 0; gi < NUM_PORT_CNT; gi++)
    begin : g_port
      // Clear as a side effect of the fetch
      // A miss or another table clears nothing
      assign port_clr[gi] = trigger && tgt.port_hit && (tgt.port_idx == 7'(gi));

      // Offset 0x0e of each block counts 64-octet frames, wired by the MAC side
      // The other offsets count whatever events the port logic wires to them
      mcir_stat_cell u_cell
      (
        .i_ref_clk(i_ref_clk),
        .i_nrst(i_nrst),
        .i_inc(i_port_stat_inc[gi]),
        .i_clr(port_clr[gi]),
        .o_count(port_count[gi]),
        .o_overflow(port_ovf[gi])
      );
    end
  endgenerate

  // Dropped-packet counters: wrap freely, never cleared by a read
  // Sixteen bits wrap silently; the host extends them by reading often enough
  generate
    for (gi = 0; gi < NUM_DROP; gi++)
    begin : g_drop
      always_ff @(posedge i_ref_clk)
      begin
        if (!i_nrst)
        begin
          // Dropped counts start from zero
          drop_cnt_ff[gi] <= '0;
        end
        else if (i_drop_inc[gi])
        begin
          // One step per pulse; a fetch of this counter leaves it alone
          drop_cnt_ff[gi] <= drop_cnt_ff[gi] + 1'b1;
        end
      end
    end
  endgenerate

  // Per-port word: overflow, valid, 30-bit count
  // Valid is always set, since a per-port word is only latched on a decoded hit
  always_comb
  begin
    port_word = '0;
    port_word.overflow = port_ovf[tgt.port_idx];
    port_word.valid = 1'b1;
    port_word.count = port_count[tgt.port_idx];
  end

  // Dropped-counter word: no flags and zero upper bits, the host tracks wraps
  always_comb
  begin
    drop_word = '0;
    drop_word.overflow = 1'b0;
    drop_word.valid = 1'b0;
    drop_word.count = {{(PORT_CNT_W-DROP_CNT_W){1'b0}}, drop_cnt_ff[tgt.drop_idx]};
  end

  // Snapshot value for the decoded target; a miss gives zero with valid low
  always_comb
  begin
    nxt_snap = '0;
    if (tgt.port_hit)
    begin
      nxt_snap = port_word;
    end
    else if (tgt.drop_hit)
    begin
      nxt_snap = drop_word;
    end
  end

  // Latch the whole word in the trigger cycle so the four reads agree
  // Reading the data registers has no side effect; the per-port clear happens here too
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_nrst)
    begin
      // A read before any fetch sees a zero word with valid low
      snap_ff <= '0;
    end
    else if (trigger)
    begin
      // One edge takes all thirty-two bits
      snap_ff <= nxt_snap;
    end
  end

  // One-cycle status pulse after a fetch
  // Lets a watcher count fetches; it carries no handshake and needs no answer
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_nrst)
    begin
      // No fetch under reset
      fetch_ff <= 1'b0;
    end
    else
    begin
      // High for exactly the cycle after a trigger
      fetch_ff <= trigger;
    end
  end

  // Status output straight from its flop
  assign o_fetch_busy = fetch_ff;

  // Register read mux: counters never appear at a direct address
  // The port samples this once per data byte, at the falling clock just before the byte's first rising clock
  always_comb
  begin
    // Default covers every unmapped address, counters included
    rd_data = 8'h00;
    if (rd_addr == REG_TABLE_SEL)
    begin
      // Table select read back as written
      rd_data = table_sel_ff;
    end
    else if (rd_addr == REG_OFFSET_TRIG)
    begin
      // Last offset written
      rd_data = offset_ff;
    end
    else if (rd_addr == REG_DATA3)
    begin
      // Flags and count bits 29:24
      rd_data = snap_ff[31:24];
    end
    else if (rd_addr == REG_DATA2)
    begin
      // Count bits 23:16
      rd_data = snap_ff[23:16];
    end
    else if (rd_addr == REG_DATA1)
    begin
      // Count bits 15:8, the top byte of a dropped count
      rd_data = snap_ff[15:8];
    end
    else if (rd_addr == REG_DATA0)
    begin
      // Least significant byte
      rd_data = snap_ff[7:0];
    end
  end

endmodule

// *** verilog/mcir_pkg.sv ***
// Purpose: Shared constants and types for the statistics counter indirect read block
// Assumes: One 100 MHz core clock, synchronous active-low reset
// Notes: Register offsets are the byte addresses seen over the serial port
package mcir_pkg;

  // Serial register port widths
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;

  // Serial port command bytes
  localparam logic [7:0] SPI_CMD_WRITE = 8'h02;
  localparam logic [7:0] SPI_CMD_READ = 8'h03;

  // Register offsets
  localparam logic [7:0] REG_TABLE_SEL = 8'h79;
  localparam logic [7:0] REG_OFFSET_TRIG = 8'h7a;
  localparam logic [7:0] REG_DATA3 = 8'h80;
  localparam logic [7:0] REG_DATA2 = 8'h81;
  localparam logic [7:0] REG_DATA1 = 8'h82;
  localparam logic [7:0] REG_DATA0 = 8'h83;

  // Reset values of the writable registers
  localparam logic [7:0] TABLE_SEL_RST = 8'h00;
  localparam logic [7:0] OFFSET_TRIG_RST = 8'h00;

  // Table select codes
  localparam logic [7:0] TABLE_PER_PORT = 8'h1c;
  localparam logic [7:0] TABLE_DROP = 8'h1d;

  // Per-port counter geometry
  localparam int unsigned NUM_PORTS = 3;
  localparam int unsigned PORT_SPAN = 32;
  localparam int unsigned NUM_PORT_CNT = NUM_PORTS * PORT_SPAN;
  localparam int unsigned PORT_CNT_W = 30;
  localparam logic [7:0] PORT1_BASE = 8'h00;
  localparam logic [7:0] PORT2_BASE = 8'h20;
  localparam logic [7:0] PORT3_BASE = 8'h40;
  localparam logic [7:0] PORT_AREA_END = 8'h60;
  localparam logic [4:0] RX_FRAMES_LEN_SIXTY_FOUR = 5'h0e;

  // Dropped-packet counter geometry (indirect offsets 0x100..0x105)
  localparam int unsigned NUM_DROP = 6;
  localparam int unsigned DROP_CNT_W = 16;
  localparam logic [8:0] DROP_AREA_BASE = 9'h100;
  localparam logic [8:0] PORT_ONE_TX_DISCARD_COUNT = 9'h100;
  localparam logic [8:0] PORT_TWO_TX_DISCARD_COUNT = 9'h101;
  localparam logic [8:0] PORT_THREE_TX_DISCARD_COUNT = 9'h102;
  localparam logic [8:0] PORT_ONE_RX_DISCARD_COUNT = 9'h103;
  localparam logic [8:0] PORT_TWO_RX_DISCARD_COUNT = 9'h104;
  localparam logic [8:0] PORT_THREE_RX_DISCARD_COUNT = 9'h105;

  // Flag positions in the 32-bit snapshot word
  localparam int unsigned SNAP_OVF_BIT = 31;
  localparam int unsigned SNAP_VALID_BIT = 30;

  // One register write from the serial port
  typedef struct packed {
    logic valid;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } mcir_reg_wr_t;

  // Snapshot word held in the four data registers
  typedef struct packed {
    logic overflow;
    logic valid;
    logic [PORT_CNT_W-1:0] count;
  } mcir_snap_t;

endpackage

// *** verilog/mcir_stat_cell.sv ***
// Purpose: One per-port statistic: 30-bit count with sticky overflow, cleared by a fetch
// Assumes: Increment and clear come from logic on the same clock
// Notes: An increment in the fetch cycle is kept as the first count after the clear
`timescale 1ns/1ns
module mcir_stat_cell
  import mcir_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  input wire logic i_inc,
  input wire logic i_clr,
  output logic [PORT_CNT_W-1:0] o_count,
  output logic o_overflow
);

  logic [PORT_CNT_W-1:0] count_ff; // Running count
  logic ovf_ff; // Sticky wrap flag
  logic wrap; // Count is about to wrap

  // A fetch in the wrap cycle restarts the count at one, so no overflow is raised then
  assign wrap = i_inc && !i_clr && (count_ff == {PORT_CNT_W{1'b1}});

  // Count update, clear on fetch keeps a same-cycle event
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_nrst)
    begin
      count_ff <= '0;
    end
    else if (i_clr)
    begin
      count_ff <= {{(PORT_CNT_W-1){1'b0}}, i_inc};
    end
    else if (i_inc)
    begin
      count_ff <= count_ff + 1'b1;
    end
  end

  // Overflow flag, set on wrap, cleared on fetch
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_nrst)
    begin
      ovf_ff <= 1'b0;
    end
    else if (wrap)
    begin
      ovf_ff <= 1'b1;
    end
    else if (i_clr)
    begin
      ovf_ff <= 1'b0;
    end
  end

  assign o_count = count_ff;
  assign o_overflow = ovf_ff;

endmodule

// *** verilog/mcir_spi_slave.sv ***
// Purpose: Serial register port, mode 0, command byte then address then data bytes
// Assumes: Serial clock well below a quarter of the core clock
// Notes: Address auto-increments after each data byte of a burst
`timescale 1ns/1ns
module mcir_spi_slave
  import mcir_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  input wire logic i_spi_sclk,
  input wire logic i_spi_cs_n,
  input wire logic i_spi_mosi,
  output logic o_spi_miso,
  output logic o_spi_miso_oe,
  output logic [ADDR_W-1:0] o_rd_addr,
  input wire logic [DATA_W-1:0] i_rd_data,
  output mcir_reg_wr_t o_wr
);

  logic [2:0] sync1_ff; // First synchroniser stage: sclk, cs_n, mosi
  logic [2:0] sync2_ff; // Second synchroniser stage
  logic sclk_d_ff; // Previous synchronised clock
  logic rise; // Serial clock rising edge
  logic fall; // Serial clock falling edge
  logic cs_act; // Chip select active
  logic [2:0] bit_ff; // Bit within byte
  logic [1:0] phase_ff; // 0 command, 1 address, 2 data
  logic [6:0] rx_ff; // Received bits of the current byte
  logic [7:0] cmd_ff; // Latched command
  logic [ADDR_W-1:0] addr_ff; // Current register address
  logic [7:0] tx_ff; // Outgoing shift register
  logic [7:0] rx_byte; // Byte completed on this edge

  // Two-flop synchronisers for the pins
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_nrst)
    begin
      sync1_ff <= 3'b010;
      sync2_ff <= 3'b010;
      sclk_d_ff <= 1'b0;
    end
    else
    begin
      sync1_ff <= {i_spi_mosi, i_spi_cs_n, i_spi_sclk};
      sync2_ff <= sync1_ff;
      sclk_d_ff <= sync2_ff[0];
    end
  end

  assign cs_act = !sync2_ff[1];
  assign rise = cs_act && sync2_ff[0] && !sclk_d_ff;
  assign fall = cs_act && !sync2_ff[0] && sclk_d_ff;
  assign rx_byte = {rx_ff, sync2_ff[2]};

  // Receive side: bit counting, command, address and write data
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_nrst || !cs_act)
    begin
      bit_ff <= 3'd0;
      phase_ff <= 2'd0;
      rx_ff <= 7'h00;
      o_wr <= '0;
      if (!i_nrst)
      begin
        cmd_ff <= 8'h00;
        addr_ff <= 8'h00;
      end
    end
    else
    begin
      o_wr.valid <= 1'b0;
      if (rise)
      begin
        rx_ff <= rx_byte[6:0];
        bit_ff <= bit_ff + 3'd1;
        if (bit_ff == 3'd7)
        begin
          // Byte complete
          if (phase_ff == 2'd0)
          begin
            cmd_ff <= rx_byte;
            phase_ff <= 2'd1;
          end
          else if (phase_ff == 2'd1)
          begin
            addr_ff <= rx_byte;
            phase_ff <= 2'd2;
          end
          else
          begin
            // Data byte: write on write command, step address either way
            o_wr.valid <= (cmd_ff == SPI_CMD_WRITE);
            o_wr.addr <= addr_ff;
            o_wr.data <= rx_byte;
            addr_ff <= addr_ff + 8'd1;
          end
        end
      end
    end
  end

  // Transmit side: load read data at byte start, else shift on falling edge
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_nrst || !cs_act)
    begin
      tx_ff <= 8'h00;
    end
    else if (fall)
    begin
      if (bit_ff == 3'd0 && phase_ff == 2'd2)
      begin
        tx_ff <= i_rd_data;
      end
      else
      begin
        tx_ff <= {tx_ff[6:0], 1'b0};
      end
    end
  end

  assign o_rd_addr = addr_ff;
  assign o_spi_miso = tx_ff[7];
  assign o_spi_miso_oe = cs_act && (cmd_ff == SPI_CMD_READ) && (phase_ff == 2'd2);

endmodule

// *** tb/mcir_spi_host.sv ***
// Purpose: Host model driving the serial register port of the counter block as master
// Assumes: Mode 0, msb first, half period of six core cycles
// Notes: Test code calls frame() hierarchically for each access
`timescale 1ns/1ns
module mcir_spi_host
(
  input wire logic i_ref_clk,
  input wire logic i_spi_miso_w,
  output logic o_spi_sclk,
  output logic o_spi_cs_n,
  output logic o_spi_mosi
);
  // Pins idle: deselected, clock low
  initial
  begin
    o_spi_sclk = 1'b0;
    o_spi_cs_n = 1'b1;
    o_spi_mosi = 1'b0;
  end

  // Command, address, then n data bytes; read bytes collect in rd
  task automatic frame(input logic [7:0] cmd, input logic [7:0] addr, input int n,
    input logic [31:0] wd, output logic [31:0] rd);
    logic [47:0] sh;
    sh = {cmd, addr, wd};
    rd = 32'h0000_0000;
    @(posedge i_ref_clk);
    o_spi_cs_n <= 1'b0;
    repeat (6) @(posedge i_ref_clk);
    for (int i = 0; i < 8 * (n + 2); i++)
    begin
      o_spi_mosi <= sh[47 - i];
      repeat (6) @(posedge i_ref_clk);
      // Sample on the rising edge, as mode 0 asks
      if (i >= 16)
        rd = {rd[30:0], i_spi_miso_w};
      o_spi_sclk <= 1'b1;
      repeat (6) @(posedge i_ref_clk);
      o_spi_sclk <= 1'b0;
    end
    repeat (6) @(posedge i_ref_clk);
    o_spi_cs_n <= 1'b1;
    // Released data line flips so a stale level never looks like data
    o_spi_mosi <= ~o_spi_mosi;
    repeat (8) @(posedge i_ref_clk);
  endtask
endmodule

// *** tb/mcir_top_chk.sv ***
// Purpose: Port-level assertions for the counter indirect read block
// Assumes: Host keeps sclk half periods of at least six core cycles
// Notes: Bound into every mcir_top instance
`timescale 1ns/1ns
module mcir_top_chk
  import mcir_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  input wire logic i_spi_sclk,
  input wire logic i_spi_cs_n,
  input wire logic i_spi_mosi,
  input wire logic o_spi_miso,
  input wire logic o_spi_miso_oe,
  input wire logic [NUM_PORT_CNT-1:0] i_port_stat_inc,
  input wire logic [NUM_DROP-1:0] i_drop_inc,
  input wire logic o_fetch_busy
);
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_nrst);

  // Select held off long enough to pass the synchroniser
  sequence s_cs_idle;
    i_spi_cs_n [*5];
  endsequence
  // Serial clock settled high
  sequence s_sclk_high;
    i_spi_sclk [*3];
  endsequence

  property p_rst_quiet;
    $rose(i_nrst) |-> !o_spi_miso_oe && !o_fetch_busy && !o_spi_miso;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet)
    else $error("outputs active right after reset");

  property p_busy_pulse;
    o_fetch_busy |=> !o_fetch_busy [*8];
  endproperty
  a_busy_pulse: assert property (p_busy_pulse)
    else $error("fetch pulse too long or too close");

  property p_busy_frame;
    o_fetch_busy |-> !$past(i_spi_cs_n, 3) && !o_spi_miso_oe;
  endproperty
  a_busy_frame: assert property (p_busy_frame)
    else $error("fetch outside a write frame");

  property p_idle_busy;
    s_cs_idle |-> !o_fetch_busy;
  endproperty
  a_idle_busy: assert property (p_idle_busy)
    else $error("fetch while deselected");

  property p_idle_oe;
    s_cs_idle |-> !o_spi_miso_oe;
  endproperty
  a_idle_oe: assert property (p_idle_oe)
    else $error("data out driven while deselected");

  property p_oe_rise;
    $rose(o_spi_miso_oe) |-> !i_spi_cs_n && !$past(i_spi_cs_n, 2);
  endproperty
  a_oe_rise: assert property (p_oe_rise)
    else $error("data out enabled outside a frame");

  property p_miso_hold;
    s_sclk_high |-> $stable(o_spi_miso);
  endproperty
  a_miso_hold: assert property (p_miso_hold)
    else $error("data out moved while clock high");

  property p_miso_fall;
    $changed(o_spi_miso) |-> !i_spi_sclk;
  endproperty
  a_miso_fall: assert property (p_miso_fall)
    else $error("data out moved off the falling phase");
endmodule

bind mcir_top mcir_top_chk u_chk (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_spi_sclk(i_spi_sclk),
  .i_spi_cs_n(i_spi_cs_n), .i_spi_mosi(i_spi_mosi), .o_spi_miso(o_spi_miso),
  .o_spi_miso_oe(o_spi_miso_oe), .i_port_stat_inc(i_port_stat_inc), .i_drop_inc(i_drop_inc),
  .o_fetch_busy(o_fetch_busy));

// *** tb/mcir_top_tb.sv ***
// Purpose: Self-checking bench for the counter indirect read block
// Assumes: Host model drives the serial port
// Notes: Counters are bumped by pulses, then fetched and read back
`timescale 1ns/1ns
module mcir_top_tb;
  import mcir_pkg::*;
  logic clk, nrst, sclk, cs_n, mosi, miso, oe, busy, miso_w;
  logic [NUM_PORT_CNT-1:0] port_inc;
  logic [NUM_DROP-1:0] drop_inc;
  logic [31:0] rd;
  logic [7:0] offs [3] = '{8'h0e, 8'h2e, 8'h4e};
  int n_errors, n_checks, n_busy;

  // Undriven line shows the inverse, so a missing answer never matches
  assign miso_w = oe ? miso : ~miso;

  mcir_top uut (.i_ref_clk(clk), .i_nrst(nrst), .i_spi_sclk(sclk), .i_spi_cs_n(cs_n),
    .i_spi_mosi(mosi), .o_spi_miso(miso), .o_spi_miso_oe(oe), .i_port_stat_inc(port_inc),
    .i_drop_inc(drop_inc), .o_fetch_busy(busy));
  mcir_spi_host u_host (.i_ref_clk(clk), .i_spi_miso_w(miso_w), .o_spi_sclk(sclk),
    .o_spi_cs_n(cs_n), .o_spi_mosi(mosi));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Counts fetch pulses
  always @(posedge clk)
    if (busy === 1'b1)
      n_busy++;

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_host.frame(SPI_CMD_WRITE, a, 1, {d, 24'h00_0000}, rd);
  endtask

  task automatic rdr(input logic [7:0] a, input int n);
    u_host.frame(SPI_CMD_READ, a, n, 32'h0000_0000, rd);
  endtask

  // n one-cycle event pulses on one counter
  task automatic bump(input int idx, input int n, input logic drop);
    repeat (n)
    begin
      @(posedge clk);
      if (drop)
        drop_inc[idx] <= 1'b1;
      else
        port_inc[idx] <= 1'b1;
      @(posedge clk);
      drop_inc <= '0;
      port_inc <= '0;
    end
  endtask

  task automatic summarize();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial
  begin
    nrst <= 1'b0;
    port_inc <= '0;
    drop_inc <= '0;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    rdr(REG_TABLE_SEL, 2);
    check("sel_trig_rst", rd[15:0], {TABLE_SEL_RST, OFFSET_TRIG_RST});
    rdr(REG_DATA3, 4);
    check("snap_rst", rd, 32'h0000_0000);
    rdr(8'h10, 1);
    check("unmapped", rd[7:0], 8'h00);
    for (int p = 0; p < 3; p++)
      bump(offs[p], p + 2, 1'b0);
    for (int k = 0; k < 6; k++)
      bump(k, k + 1, 1'b1);
    wr(REG_TABLE_SEL, TABLE_PER_PORT);
    for (int p = 0; p < 3; p++)
    begin
      wr(REG_OFFSET_TRIG, offs[p]);
      rdr(REG_DATA3, 4);
      check("port_cnt", rd, {2'b01, 30'(p + 2)});
    end
    wr(REG_OFFSET_TRIG, offs[0]);
    rdr(REG_DATA3, 4);
    check("port_cleared", rd, 32'h4000_0000);
    // Data registers ignore writes
    wr(REG_DATA3, 8'hff);
    rdr(REG_DATA3, 4);
    check("ro_data", rd, 32'h4000_0000);
    rdr(REG_OFFSET_TRIG, 1);
    check("trig_back", rd[7:0], offs[0]);
    wr(REG_TABLE_SEL, TABLE_DROP);
    for (int k = 0; k < 6; k++)
    begin
      wr(REG_OFFSET_TRIG, 8'(k));
      rdr(REG_DATA1, 2);
      check("drop_cnt", rd[15:0], 16'(k + 1));
      rdr(REG_DATA3, 2);
      check("drop_flags", rd[15:0], 16'h0000);
    end
    wr(REG_OFFSET_TRIG, 8'h00);
    rdr(REG_DATA1, 2);
    check("drop_kept", rd[15:0], 16'h0001);
    // Misses and an unknown table fetch a zero word with valid low
    wr(REG_OFFSET_TRIG, 8'h06);
    rdr(REG_DATA3, 4);
    check("drop_miss", rd, 32'h0000_0000);
    wr(REG_TABLE_SEL, TABLE_PER_PORT);
    wr(REG_OFFSET_TRIG, PORT_AREA_END);
    rdr(REG_DATA3, 4);
    check("port_miss", rd, 32'h0000_0000);
    // An unknown command writes nothing
    u_host.frame(8'h05, REG_TABLE_SEL, 1, 32'h5500_0000, rd);
    rdr(REG_TABLE_SEL, 1);
    check("bad_cmd", rd[7:0], TABLE_PER_PORT);
    wr(REG_TABLE_SEL, 8'h55);
    wr(REG_OFFSET_TRIG, offs[1]);
    rdr(REG_DATA3, 4);
    check("bad_table", rd, 32'h0000_0000);
    check("fetches", n_busy, 32'h0000_000e);
    summarize();
  end
endmodule
